/* File: inc/fsw_pkg.sv */
package fsw_pkg;
	// window counter width: enough for the dropout limit
	localparam int          FSW_CNT_W        = 8;
	localparam logic [7:0]  FSW_CNT_ZERO     = 8'h00;
	localparam logic [7:0]  FSW_CNT_ONE      = 8'h01;
	// window limits in timebase clocks, hysteresis picks one of each pair
	localparam logic [7:0]  FSW_LOW_FAIL     = 8'h4f;
	localparam logic [7:0]  FSW_LOW_GOOD     = 8'h50;
	localparam logic [7:0]  FSW_HIGH_FAIL    = 8'ha9;
	localparam logic [7:0]  FSW_HIGH_GOOD    = 8'haa;
	localparam logic [7:0]  FSW_DROPOUT      = 8'hfa;
	// fault counter saturation range
	localparam logic [1:0]  FSW_UD_MIN       = 2'h0;
	localparam logic [1:0]  FSW_UD_MAX       = 2'h3;
	localparam logic [1:0]  FSW_UD_STEP      = 2'h1;
	// timebase period and supply debounce / reset delay
	localparam int          FSW_CLK_NS       = 100;
	localparam int          FSW_DEB_NS       = 1000;
	localparam int          FSW_RDLY_NS      = 10000;
	localparam int          FSW_DEB_CYC      = (FSW_DEB_NS + FSW_CLK_NS - 1)
		/ FSW_CLK_NS;
	localparam int          FSW_RDLY_CYC     = (FSW_RDLY_NS + FSW_CLK_NS - 1)
		/ FSW_CLK_NS;
	localparam logic [7:0]  FSW_DEB_LIM      = 8'(FSW_DEB_CYC);
	localparam logic [7:0]  FSW_RDLY_LIM     = 8'(FSW_RDLY_CYC);

	typedef enum logic [1:0]
	{
		FSW_SUP_OK,
		FSW_SUP_DEB,
		FSW_SUP_DELAY
	} fsw_sup_t;
endpackage : fsw_pkg

/* File: inc/fsw_wd_if.sv */
// watchdog state handed from the window core to the output stage
interface fsw_wd_if;
	logic wd_rst;
	logic trig_evt;
	logic window_good;

	modport core
	(
		input  wd_rst,
		input  trig_evt,
		output window_good
	);
	modport ctl
	(
		output wd_rst,
		output trig_evt,
		input  window_good
	);
endinterface : fsw_wd_if

/* File: core/fsw_sync.sv */
// two-stage synchroniser followed by rising-edge detector
module fsw_sync
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      level,
	output logic      rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	// first stage is read only by the second
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~last_q;
endmodule : fsw_sync

/* File: core/fsw_window.sv */
// window timing counter, saturating up/down counter and good flag
module fsw_window
	import fsw_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	fsw_wd_if.core    wd
);
	logic [7:0] tmr_q;
	logic [7:0] tmr_d;
	logic [1:0] ud_q;
	logic [1:0] ud_d;
	logic       good_q;
	logic       good_d;
	logic [7:0] lim_lo;
	logic [7:0] lim_hi;
	logic       in_win;
	logic       dropout;

	// hysteresis mux: good flag widens the window by one clock at each end
	assign lim_lo  = good_q ? FSW_LOW_FAIL : FSW_LOW_GOOD;
	assign lim_hi  = good_q ? FSW_HIGH_GOOD : FSW_HIGH_FAIL;
	assign in_win  = (tmr_q >= lim_lo) && (tmr_q <= lim_hi);
	assign dropout = (tmr_q >= FSW_DROPOUT);

	// timer stops at dropout so it cannot wrap into the window; restart at
	// one because the event edge is the first clock of the new interval
	assign tmr_d = wd.trig_evt ? FSW_CNT_ONE
		: (dropout ? tmr_q : tmr_q + FSW_CNT_ONE);

	always_comb
	begin
		ud_d   = ud_q;
		good_d = good_q;
		if (dropout)
		begin
			ud_d   = FSW_UD_MIN;
			good_d = 1'b0;
		end
		else if (wd.trig_evt)
		begin
			if (in_win && ud_q != FSW_UD_MAX)
				ud_d = ud_q + FSW_UD_STEP;
			else if (!in_win && ud_q != FSW_UD_MIN)
				ud_d = ud_q - FSW_UD_STEP;
			if (ud_d == FSW_UD_MAX)
				good_d = 1'b1;
			else if (ud_d == FSW_UD_MIN)
				good_d = 1'b0;
		end
	end

	// synchronous watchdog reset covers supply and timebase faults
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tmr_q  <= FSW_CNT_ZERO;
			ud_q   <= FSW_UD_MIN;
			good_q <= 1'b0;
		end
		else if (wd.wd_rst)
		begin
			tmr_q  <= FSW_CNT_ZERO;
			ud_q   <= FSW_UD_MIN;
			good_q <= 1'b0;
		end
		else
		begin
			tmr_q  <= tmr_d;
			ud_q   <= ud_d;
			good_q <= good_d;
		end
	end

	assign wd.window_good = good_q;
endmodule : fsw_window

/* File: core/fsw_top.sv */
// What this block does
// - relay on when requested and healthy
// - fet gate on when requested and healthy
// - supply fault asserts resets, drops enables, drivers
// - trigger rise restarts timer at one, clocks fault counter
// - fault counter saturates 0..3, up good, down bad
// - counter at three sets window good
// - counter back to zero clears window good
// - 250 clocks without trigger resets counter, flag
// - window 80..169 good, outside fast or slow
// - 250 clocks or more is a dropout
// - good flag shifts window limits by one
// - timebase fault resets counter, clears good
// - power-on or voltage fault resets watchdog
// - start at count zero, fault status
// - bad trigger drops drivers, enables, not resets
// - short supply glitch ignored, long restarts delay
module fsw_top
	import fsw_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic trigger_in,
	input  wire logic relay_request_in,
	input  wire logic fet_request_in,
	input  wire logic vcc_fault_in,
	input  wire logic v33_fault_in,
	input  wire logic timebase_fault,
	output logic      relay_drive_out,
	output logic      fet_gate_out,
	output logic      reset_out_active_high,
	output logic      reset_out_active_low,
	output logic      enable_out_active_high,
	output logic      enable_out_active_low,
	output logic      window_good
);
	fsw_wd_if wd ();

	logic       trig_rise;
	logic       relay_req;
	logic       fet_req;
	logic       vfault;
	logic       osc_fault;
	logic       vcc_f;
	logic       v33_f;
	fsw_sup_t   sup_q;
	fsw_sup_t   sup_d;
	logic [7:0] deb_q;
	logic [7:0] deb_d;
	logic [7:0] deb_inc;
	logic       deb_done;
	logic       dly_done;
	logic       sup_rst;
	logic       wd_bad;
	logic       rel_d;
	logic       fet_d;
	logic       en_d;
	logic       rel_q;
	logic       fet_q;
	logic       en_q;
	logic       en_n_q;
	logic       res_q;
	logic       res_n_q;
	logic       good_q;

	// one step of the shared supervisor counter
	function automatic logic [7:0] fsw_step(input logic [7:0] v);
		return v + FSW_CNT_ONE;
	endfunction : fsw_step

	// every pin input except rst_b is synchronised before use
	fsw_sync u_trig
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (trigger_in),
		.level   (),
		.rise    (trig_rise)
	);
	fsw_sync u_rel
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (relay_request_in),
		.level   (relay_req),
		.rise    ()
	);
	fsw_sync u_fet
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (fet_request_in),
		.level   (fet_req),
		.rise    ()
	);
	fsw_sync u_vcc
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (vcc_fault_in),
		.level   (vcc_f),
		.rise    ()
	);
	fsw_sync u_v33
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (v33_fault_in),
		.level   (v33_f),
		.rise    ()
	);
	fsw_sync u_osc
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.din     (timebase_fault),
		.level   (osc_fault),
		.rise    ()
	);

	// counter decode shared by the debounce and the reset delay states;
	// the limits are ceilings, so a slower timebase only lengthens them
	assign deb_inc  = fsw_step(deb_q);
	assign deb_done = (deb_inc >= FSW_DEB_LIM);
	assign dly_done = (deb_inc >= FSW_RDLY_LIM);

	// either supply wrong counts as one fault
	assign vfault = vcc_f | v33_f;

	// supply supervisor: debounce, then reset delay restarted by new pulse
	always_comb
	begin
		sup_d = sup_q;
		deb_d = deb_q;
		case (sup_q)
			FSW_SUP_OK:
			begin
				deb_d = FSW_CNT_ZERO;
				if (vfault)
					sup_d = FSW_SUP_DEB;
			end
			FSW_SUP_DEB:
			begin
				if (!vfault)
					sup_d = FSW_SUP_OK;
				else if (deb_done)
				begin
					sup_d = FSW_SUP_DELAY;
					deb_d = FSW_CNT_ZERO;
				end
				else
					deb_d = deb_inc;
			end
			// any fault level in the delay restarts it, so the total
			// reset time can exceed one delay
			FSW_SUP_DELAY:
			begin
				if (vfault)
					deb_d = FSW_CNT_ZERO;
				else if (dly_done)
					sup_d = FSW_SUP_OK;
				else
					deb_d = deb_inc;
			end
			default:
			begin
				sup_d = FSW_SUP_DELAY;
				deb_d = FSW_CNT_ZERO;
			end
		endcase
	end

	// power-on starts in the reset delay, so resets assert first
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sup_q <= FSW_SUP_DELAY;
		end
		else
		begin
			sup_q <= sup_d;
		end
	end

	// debounce and delay share one counter; the state says which it is
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			deb_q <= FSW_CNT_ZERO;
		end
		else
		begin
			deb_q <= deb_d;
		end
	end

	assign sup_rst   = (sup_q == FSW_SUP_DELAY);
	assign wd.wd_rst = sup_rst | osc_fault;
	assign wd.trig_evt = trig_rise;

	fsw_window u_win
	(
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wd      (wd)
	);

	// truth table: drivers need request, good supply and good trigger
	assign wd_bad = ~wd.window_good;
	assign en_d   = ~sup_rst & wd.window_good;
	assign rel_d  = relay_req & ~sup_rst & ~wd_bad;
	assign fet_d  = fet_req & ~sup_rst & ~wd_bad;

	// every pin has its own flop, so no output glitches through a gate;
	// a bad trigger alone drops the drivers but never the resets
	// relay driver flop
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rel_q <= 1'b0;
		end
		else
		begin
			rel_q <= rel_d;
		end
	end

	// fet gate flop
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fet_q <= 1'b0;
		end
		else
		begin
			fet_q <= fet_d;
		end
	end

	// active-high enable flop
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			en_q <= 1'b0;
		end
		else
		begin
			en_q <= en_d;
		end
	end

	// active-low enable flop, disabled level is high
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			en_n_q <= 1'b1;
		end
		else
		begin
			en_n_q <= ~en_d;
		end
	end

	// active-high reset flop, asserted through power-on
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_q <= 1'b1;
		end
		else
		begin
			res_q <= sup_rst;
		end
	end

	// active-low reset flop, mirrors the one above
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			res_n_q <= 1'b0;
		end
		else
		begin
			res_n_q <= ~sup_rst;
		end
	end

	// window good copy, aligned with the driver flops
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			good_q <= 1'b0;
		end
		else
		begin
			good_q <= wd.window_good;
		end
	end

	assign relay_drive_out        = rel_q;
	assign fet_gate_out           = fet_q;
	assign enable_out_active_high = en_q;
	assign enable_out_active_low  = en_n_q;
	assign reset_out_active_high  = res_q;
	assign reset_out_active_low   = res_n_q;
	assign window_good            = good_q;
endmodule : fsw_top

/* File: tb/fsw_top_monitor.sv */
module fsw_top_monitor
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic trigger_in,
	input wire logic relay_request_in,
	input wire logic fet_request_in,
	input wire logic vcc_fault_in,
	input wire logic v33_fault_in,
	input wire logic timebase_fault,
	input wire logic relay_drive_out,
	input wire logic fet_gate_out,
	input wire logic reset_out_active_high,
	input wire logic reset_out_active_low,
	input wire logic enable_out_active_high,
	input wire logic enable_out_active_low,
	input wire logic window_good
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	logic [8:0] quiet_q;
	logic [8:0] quiet_d;
	logic       trig_q;

	// clocks since the last trigger rise at the pin, saturating
	assign quiet_d = (trigger_in && !trig_q) ? 9'h000 :
		((quiet_q == 9'h1ff) ? quiet_q : quiet_q + 9'h001);

	// pin-level count: sync delay is well inside the dropout margin
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			quiet_q <= 9'h000;
		else
			quiet_q <= quiet_d;
	end

	// previous trigger level for the edge test above
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			trig_q <= 1'b0;
		else
			trig_q <= trigger_in;
	end

	AST_RES_PAIR: assert property (
		reset_out_active_low == !reset_out_active_high)
		else $error("reset outputs not complementary");
	AST_EN_PAIR: assert property (
		enable_out_active_low == !enable_out_active_high)
		else $error("enable outputs not complementary");
	AST_RES_DROP: assert property (
		$rose(reset_out_active_high) |->
		!relay_drive_out && !fet_gate_out && !enable_out_active_high)
		else $error("drivers or enable on during reset");
	AST_REL_OFF: assert property (
		$fell(relay_request_in) |-> ##[1:4] !relay_drive_out)
		else $error("relay stays on after request drop");
	AST_FET_OFF: assert property (
		$fell(fet_request_in) |-> ##[1:4] !fet_gate_out)
		else $error("fet stays on after request drop");
	AST_REL_GOOD: assert property (
		relay_drive_out |-> window_good || $past(window_good))
		else $error("relay on without window good");
	AST_EN_SET: assert property (
		$rose(window_good) |-> ##[0:1] enable_out_active_high)
		else $error("enable not raised with window good");
	AST_EN_CLR: assert property (
		$fell(window_good) |-> ##[0:1] !enable_out_active_high)
		else $error("enable not dropped with window good");
	AST_DROPOUT: assert property (
		quiet_q == 9'h104 |-> !window_good)
		else $error("window good kept after trigger dropout");
	AST_OSC: assert property (
		$rose(timebase_fault) |-> ##[1:6] !window_good)
		else $error("window good kept on timebase fault");
	AST_START: assert property (
		$rose(rst_b) |-> !window_good [*8])
		else $error("window good right after reset");

	COV_GOOD: cover property ($rose(window_good));
	COV_BAD: cover property ($fell(window_good));
	COV_RES: cover property ($rose(reset_out_active_high));
	COV_DROP: cover property (quiet_q == 9'h104 && !window_good);
endmodule : fsw_top_monitor

bind fsw_top fsw_top_monitor fsw_top_monitor_i (.*);

/* File: tb/fsw_mcu_model.sv */
module fsw_mcu_model
(
	input  wire logic       ref_clk,
	input  wire logic [8:0] period,
	output logic            trigger_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [8:0] phase_q = 9'h000;
	logic [8:0] phase_d;

	initial trigger_out = 1'b0;

	// steady pulse train, period in timebase clocks; zero keeps it low
	assign phase_d = (phase_q + 9'h001 >= period) ? 9'h000
		: phase_q + 9'h001;

	// changes on the falling edge, away from the sampling edge
	always @(negedge ref_clk)
	begin
		phase_q <= phase_d;
		trigger_out <= (period != 9'h000)
			&& (phase_q < (period >> 1));
	end
endmodule : fsw_mcu_model

/* File: tb/fsw_top_tb_top.sv */
module fsw_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic       ref_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       trigger_in;
	logic       relay_request_in = 1'b1;
	logic       fet_request_in = 1'b1;
	logic       vcc_fault_in = 1'b0;
	logic       v33_fault_in = 1'b0;
	logic       timebase_fault = 1'b0;
	logic       relay_drive_out;
	logic       fet_gate_out;
	logic       reset_out_active_high;
	logic       reset_out_active_low;
	logic       enable_out_active_high;
	logic       enable_out_active_low;
	logic       window_good;
	logic [8:0] period = 9'h000;
	int         err_count = 0;
	int         total_checks = 0;

	// 10 MHz timebase
	always #50 ref_clk = ~ref_clk;

	fsw_top fsw_top_i (.*);
	fsw_mcu_model fsw_mcu_model_i
	(
		.ref_clk     (ref_clk),
		.period      (period),
		.trigger_out (trigger_in)
	);

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// order: relay, fet, active-high reset, active-high enable
	task automatic chk(input string      what,
		input logic [3:0] e,
		input logic [3:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s exp %b got %b", what, e, g);
		end
	endtask : chk

	task automatic outs(input logic [3:0] e);
		chk("outputs", e, {relay_drive_out, fet_gate_out,
			reset_out_active_high, enable_out_active_high});
		// low-active pins must mirror their active-high partners
		chk("low outputs", {2'h0, ~e[1], ~e[0]},
			{2'h0, reset_out_active_low, enable_out_active_low});
	endtask : outs

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	// bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_good(input logic e, input int bound);
		int n;
		n = 0;
		while (window_good !== e && n < bound)
		begin
			cyc(1);
			n++;
		end
		chk("window_good", {3'h0, e}, {3'h0, window_good});
		if (window_good !== e)
			summarize();
	endtask : wait_good

	task automatic go_good();
		cyc(1);
		period = 9'h064;
		wait_good(1'b1, 900);
		cyc(3);
	endtask : go_good

	task automatic t_power_on();
		cyc(5);
		outs(4'h2);
		rst_b = 1'b1;
		cyc(110);
		outs(4'h0);
	endtask : t_power_on

	task automatic t_requests();
		go_good();
		outs(4'hd);
		relay_request_in = 1'b0;
		fet_request_in = 1'b0;
		cyc(6);
		outs(4'h1);
		relay_request_in = 1'b1;
		fet_request_in = 1'b1;
	endtask : t_requests

	// too fast and too slow walk the counter back to zero; silent hits the dropout
	task automatic t_bad(input logic [8:0] p, input int bound);
		go_good();
		period = p;
		wait_good(1'b0, bound);
		outs(4'h0);
	endtask : t_bad

	// period 170 sits only inside the widened window of the good state
	task automatic t_hyst();
		go_good();
		period = 9'h0aa;
		cyc(700);
		outs(4'hd);
		period = 9'h000;
		cyc(300);
		period = 9'h0aa;
		cyc(900);
		outs(4'h0);
	endtask : t_hyst

	task automatic t_osc();
		go_good();
		timebase_fault = 1'b1;
		wait_good(1'b0, 10);
		timebase_fault = 1'b0;
	endtask : t_osc

	task automatic t_supply(input logic which);
		go_good();
		{vcc_fault_in, v33_fault_in} = which ? 2'h1 : 2'h2;
		cyc(5);
		{vcc_fault_in, v33_fault_in} = 2'h0;
		cyc(20);
		outs(4'hd);
		{vcc_fault_in, v33_fault_in} = which ? 2'h1 : 2'h2;
		cyc(20);
		outs(4'h2);
		{vcc_fault_in, v33_fault_in} = 2'h0;
		cyc(40);
		{vcc_fault_in, v33_fault_in} = which ? 2'h1 : 2'h2;
		cyc(15);
		{vcc_fault_in, v33_fault_in} = 2'h0;
		cyc(60);
		outs(4'h2);
		cyc(120);
		outs(4'h0);
	endtask : t_supply

	// main sequence
	initial
	begin
		t_power_on();
		t_requests();
		t_bad(9'h028, 500);
		t_bad(9'h0c8, 900);
		t_bad(9'h000, 280);
		t_hyst();
		t_osc();
		t_supply(1'b0);
		t_supply(1'b1);
		summarize();
	end
endmodule : fsw_top_tb_top
